// [rtl/icr_indexed_ctrl.sv]
// indexed control register set with shared-address access qualification
`timescale 1ns/100ps
// Contract
// - one window reaches indexed set via scratch index
// - window reads need window-read-enable set
// - window-read-enable set hides the shared standard read
// - flow key value in line format blocks window
// - divisor latch bit set hides only the additional status register at the shared address
// - standard-only registers need additional-status-enable clear
// - read-standard-only reads need enable clear; writes unaffected
// - additional status registers mapped when enable set
// - additional status: only bits 0,1 writable
// - soft reset key resets channel, keeps clock selects
// - flow low threshold holds 7 bits only
// - prescaler resets to 0x20, others zero
module icr_indexed_ctrl #(
  parameter logic [7:0] ID1_VALUE  = 8'hA5,  // arbitrary identification value
  parameter logic [7:0] ID2_VALUE  = 8'h5A,  // arbitrary identification value
  parameter logic [7:0] ID3_VALUE  = 8'h3C,  // arbitrary identification value
  parameter logic [7:0] REV_VALUE  = 8'h01,  // arbitrary revision value
  parameter logic [7:0] PORT_INDEX = 8'h00   // arbitrary port number
) (
  // clock and reset
  input  wire logic                    SYS_CLK_IN,
  input  wire logic                    RST_N_IN,
  // host register port
  input  wire logic                    CS_IN,
  input  wire logic                    RD_IN,
  input  wire logic                    WR_IN,
  input  wire logic [2:0]              ADDR_IN,
  input  wire logic [7:0]              DATA_IN,
  output logic      [7:0]              DATA_OUT,
  output logic                         DATA_OE_OUT,
  // standard register file of the channel
  output logic                         STD_RD_OUT,
  output logic                         STD_WR_OUT,
  output logic      [2:0]              STD_ADDR_OUT,
  output logic      [7:0]              STD_WDATA_OUT,
  input  wire logic [7:0]              STD_RDATA_IN,
  // channel status inputs
  input  wire logic [7:0]              ASR_STATUS_IN,
  input  wire logic [7:0]              RFL_IN,
  input  wire logic [7:0]              TFL_IN,
  input  wire logic [7:0]              FCR_READBACK_IN,
  input  wire logic                    GOOD_DATA_IN,
  input  wire logic                    TXRDY_STAT_IN,
  input  wire logic                    RXRDY_STAT_IN,
  // control outputs
  output icr_pkg::icr_ctrl_s           CFG_OUT,
  output logic      [7:0]              LINE_FORMAT_OUT,
  output logic      [1:0]              ASR_CTRL_OUT,
  output logic                         CHAN_RESET_OUT
);
  import icr_pkg::*;

  logic                                wr_req;
  logic                                rd_req;
  logic [7:0]                          lcr_reg;
  logic [7:0]                          spr_reg;
  logic [1:0]                          asr_ctrl_reg;
  logic                                flow_key;
  logic                                dlab;
  logic                                win_rd_en;
  logic                                asr_en;
  logic [7:0]                          additional_control;
  logic                                mem_we;
  logic [MEM_AW-1:0]                   mem_waddr;
  logic [7:0]                          mem_wdata;
  logic [MEM_AW-1:0]                   mem_raddr;
  logic [7:0]                          mem_rdata;
  logic [MEM_DEPTH*DATA_W-1:0]         mem_dump;
  logic                                soft_rst;
  logic                                lcr_we;
  logic                                spr_we;
  logic                                asr_we;
  logic                                std_we;
  icr_src_e                            rd_src;
  logic [7:0]                          rd_val;
  icr_src_e                            rd_src_reg;
  logic [7:0]                          rd_val_reg;
  logic                                rd_pend_reg;

  // one byte of the flat storage view
  function automatic logic [7:0] slot(input logic [MEM_DEPTH*DATA_W-1:0] d,
                                      input logic [7:0] idx);
    return d[idx*DATA_W +: DATA_W];
  endfunction

  // storage slot of a flow-character address
  function automatic logic [MEM_AW-1:0] flow_slot(input logic [2:0] a);
    return {FLOW_SLOT_TOP, a};
  endfunction

  // live value of read-only indexed bits; storage holds zero in those bits
  function automatic logic [7:0] ro_value(input logic [7:0] idx);
    if (idx == IDX_ID1) return ID1_VALUE;
    else if (idx == IDX_ID2) return ID2_VALUE;
    else if (idx == IDX_ID3) return ID3_VALUE;
    else if (idx == IDX_REV) return REV_VALUE;
    else if (idx == IDX_RFC) return FCR_READBACK_IN;
    else if (idx == IDX_GDS) return {7'h00, GOOD_DATA_IN};
    else if (idx == IDX_DMS) return {6'h00, TXRDY_STAT_IN, RXRDY_STAT_IN};
    else if (idx == IDX_PID) return PORT_INDEX;
    else return RST_ZERO;
  endfunction

  // a read and a write in the same cycle: the write is taken, the read dropped
  assign wr_req = CS_IN & WR_IN;
  assign rd_req = CS_IN & RD_IN & ~WR_IN;

  // qualifiers seen by the decodes; window-read-enable by the read decode only
  assign additional_control       = slot(mem_dump, IDX_ACR);
  assign flow_key  = (lcr_reg == LCR_FLOW_KEY);
  assign dlab      = lcr_reg[LCR_DLAB_BIT];
  assign win_rd_en = additional_control[ACR_WIN_RD_BIT];
  assign asr_en    = additional_control[ACR_ASR_EN_BIT];

  // write decode; the flow key is tested first so the window is unreachable under it
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = '0;
    mem_wdata = '0;
    soft_rst  = 1'b0;
    lcr_we    = 1'b0;
    spr_we    = 1'b0;
    asr_we    = 1'b0;
    std_we    = 1'b0;
    if (wr_req) begin
      if (flow_key && is_flow_addr(ADDR_IN)) begin
        mem_we    = 1'b1;
        mem_waddr = flow_slot(ADDR_IN);
        mem_wdata = DATA_IN;
      end else if (ADDR_IN == ADDR_LCR) begin
        lcr_we = 1'b1;
      end else if (ADDR_IN == ADDR_SPR) begin
        spr_we = 1'b1;
      end else if (ADDR_IN == ADDR_WIN) begin
        if (spr_reg == IDX_CSR) begin
          soft_rst = (DATA_IN == CSR_RESET_KEY);
        end else if (idx_wmask(spr_reg) != MASK_NONE) begin
          mem_we    = 1'b1;
          mem_waddr = spr_reg[MEM_AW-1:0];
          mem_wdata = DATA_IN & idx_wmask(spr_reg);
        end
      end else if (ADDR_IN == ADDR_SHARED1 && !dlab && asr_en) begin
        asr_we = 1'b1;
      end else begin
        std_we = 1'b1;
      end
    end
  end

  // read decode; every source but the standard file and stored data is captured now in rd_val
  always_comb begin
    rd_src    = SRC_STD;
    rd_val    = RST_ZERO;
    mem_raddr = spr_reg[MEM_AW-1:0];
    if (flow_key && is_flow_addr(ADDR_IN)) begin
      rd_src    = SRC_MEM;
      mem_raddr = flow_slot(ADDR_IN);
    end else if (ADDR_IN == ADDR_SPR) begin
      rd_src = SRC_HELD;
      rd_val = spr_reg;
    end else if (ADDR_IN == ADDR_LCR) begin
      rd_src = SRC_HELD;
      rd_val = asr_en ? RFL_IN : lcr_reg;
    end else if (ADDR_IN == ADDR_TFL && asr_en) begin
      rd_src = SRC_HELD;
      rd_val = TFL_IN;
    end else if (ADDR_IN == ADDR_WIN) begin
      if (win_rd_en) begin
        if (spr_reg <= IDX_CKA) begin
          rd_src = SRC_MEM;
          rd_val = ro_value(spr_reg);
        end else begin
          rd_src = SRC_HELD;
        end
      end else if (asr_en) begin
        rd_src = SRC_HELD;
      end
    end else if (ADDR_IN == ADDR_SHARED1 && !dlab && asr_en) begin
      rd_src = SRC_HELD;
      rd_val = {ASR_STATUS_IN[7:2], asr_ctrl_reg};
    end
  end

  // indexed storage, flow characters in the top slots
  icr_regmem #(
    .WIDTH       (DATA_W),
    .DEPTH       (MEM_DEPTH),
    .AW          (MEM_AW),
    .RESET_IMAGE (MEM_RESET_IMAGE),
    .KEEP_MASK   (MEM_KEEP_MASK)
  ) u_regmem (
    .clk_in      (SYS_CLK_IN),
    .rst_n_in    (RST_N_IN),
    .wr_en_in    (mem_we),
    .wr_addr_in  (mem_waddr),
    .wr_data_in  (mem_wdata),
    .clr_in      (soft_rst),
    .rd_addr_in  (mem_raddr),
    .rd_data_out (mem_rdata),
    .dump_out    (mem_dump)
  );

  // line format control; the last value written decides the flow key
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      lcr_reg <= RST_ZERO;
    end else if (soft_rst) begin
      lcr_reg <= RST_ZERO;
    end else if (lcr_we) begin
      lcr_reg <= DATA_IN;
    end
  end

  // scratch index register
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      spr_reg <= RST_ZERO;
    end else if (soft_rst) begin
      spr_reg <= RST_ZERO;
    end else if (spr_we) begin
      spr_reg <= DATA_IN;
    end
  end

  // additional status: the two low bits are the only stored ones
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      asr_ctrl_reg <= ASR_WR_BITS;
    end else if (soft_rst) begin
      asr_ctrl_reg <= ASR_WR_BITS;
    end else if (asr_we) begin
      asr_ctrl_reg <= DATA_IN[1:0];
    end
  end

  // standard register strobes, one cycle after the host request
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      STD_RD_OUT    <= 1'b0;
      STD_WR_OUT    <= 1'b0;
      STD_ADDR_OUT  <= '0;
      STD_WDATA_OUT <= RST_ZERO;
    end else begin
      STD_RD_OUT <= rd_req && (rd_src == SRC_STD);
      STD_WR_OUT <= std_we;
      if (wr_req || rd_req) begin
        STD_ADDR_OUT <= ADDR_IN;
      end
      if (std_we) begin
        STD_WDATA_OUT <= DATA_IN;
      end
    end
  end

  // read pipeline stage one: remember where the answer comes from
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rd_pend_reg <= 1'b0;
      rd_src_reg  <= SRC_HELD;
      rd_val_reg  <= RST_ZERO;
    end else begin
      rd_pend_reg <= rd_req;
      if (rd_req) begin
        rd_src_reg <= rd_src;
        rd_val_reg <= rd_val;
      end
    end
  end

  // read pipeline stage two: answer to the host for exactly one cycle
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      DATA_OUT    <= RST_ZERO;
      DATA_OE_OUT <= 1'b0;
    end else begin
      DATA_OE_OUT <= rd_pend_reg;
      if (rd_pend_reg) begin
        case (rd_src_reg)
          SRC_STD: DATA_OUT <= STD_RDATA_IN;
          SRC_MEM: DATA_OUT <= mem_rdata | rd_val_reg;
          default: DATA_OUT <= rd_val_reg;
        endcase
      end
    end
  end

  // soft reset pulse to the rest of the channel
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      CHAN_RESET_OUT <= 1'b0;
    end else begin
      CHAN_RESET_OUT <= soft_rst;
    end
  end

  // control fields, registered copies of storage; one cycle behind a write
  always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      CFG_OUT         <= '0;
      LINE_FORMAT_OUT <= RST_ZERO;
      ASR_CTRL_OUT    <= ASR_WR_BITS;
    end else begin
      CFG_OUT.additional_control       <= additional_control;
      CFG_OUT.clock_prescaler       <= slot(mem_dump, IDX_CPR);
      CFG_OUT.sampling_clock_count       <= slot(mem_dump, IDX_TCR);
      CFG_OUT.clock_source_select       <= slot(mem_dump, IDX_CKS);
      CFG_OUT.ttl       <= slot(mem_dump, IDX_TTL);
      CFG_OUT.rtl       <= slot(mem_dump, IDX_RTL);
      CFG_OUT.flow_low_threshold       <= slot(mem_dump, IDX_FCL);
      CFG_OUT.flow_high_threshold       <= slot(mem_dump, IDX_FCH);
      CFG_OUT.nine_bit_mode_control       <= slot(mem_dump, IDX_NMR);
      CFG_OUT.modem_wakeup_mask       <= slot(mem_dump, IDX_MDM);
      CFG_OUT.dms_force <= mem_dump[IDX_DMS*DATA_W + 6 +: 2];  // only the two force bits
      CFG_OUT.clock_alteration       <= slot(mem_dump, IDX_CKA);
      CFG_OUT.efr       <= mem_dump[flow_slot(ADDR_FLOW0)*DATA_W +: DATA_W];
      CFG_OUT.xon1      <= mem_dump[flow_slot(3'h4)*DATA_W +: DATA_W];
      CFG_OUT.xon2      <= mem_dump[flow_slot(3'h5)*DATA_W +: DATA_W];
      CFG_OUT.xoff1     <= mem_dump[flow_slot(3'h6)*DATA_W +: DATA_W];
      CFG_OUT.xoff2     <= mem_dump[flow_slot(3'h7)*DATA_W +: DATA_W];
      LINE_FORMAT_OUT   <= lcr_reg;
      ASR_CTRL_OUT      <= asr_ctrl_reg;
    end
  end

endmodule // icr_indexed_ctrl

// [rtl/icr_pkg.sv]
// shared constants, types and decode helpers for the indexed control register block
package icr_pkg;

  // widths and storage shape
  localparam int DATA_W    = 8;
  localparam int MEM_DEPTH = 32;
  localparam int MEM_AW    = 5;

  // host port addresses (3-bit register port)
  localparam logic [2:0] ADDR_SHARED1 = 3'h1;  // divisor high / interrupt enable / additional status
  localparam logic [2:0] ADDR_FLOW0   = 3'h2;  // first flow-character slot
  localparam logic [2:0] ADDR_LCR     = 3'h3;  // line format control, receive level on read when additional status is enabled
  localparam logic [2:0] ADDR_TFL     = 3'h4;  // modem control, transmit level on read when additional status is enabled
  localparam logic [2:0] ADDR_WIN     = 3'h5;  // indexed window / line status
  localparam logic [2:0] ADDR_SPR     = 3'h7;  // scratch index register

  // qualifier values and bit positions
  localparam logic [7:0] LCR_FLOW_KEY   = 8'hBF;
  localparam logic [7:0] CSR_RESET_KEY  = 8'h00;
  localparam int         LCR_DLAB_BIT   = 7;
  localparam int         ACR_WIN_RD_BIT = 6;
  localparam int         ACR_ASR_EN_BIT = 7;

  // indexed offsets
  localparam logic [7:0] IDX_ACR = 8'h00;
  localparam logic [7:0] IDX_CPR = 8'h01;
  localparam logic [7:0] IDX_TCR = 8'h02;
  localparam logic [7:0] IDX_CKS = 8'h03;
  localparam logic [7:0] IDX_TTL = 8'h04;
  localparam logic [7:0] IDX_RTL = 8'h05;
  localparam logic [7:0] IDX_FCL = 8'h06;
  localparam logic [7:0] IDX_FCH = 8'h07;
  localparam logic [7:0] IDX_ID1 = 8'h08;
  localparam logic [7:0] IDX_ID2 = 8'h09;
  localparam logic [7:0] IDX_ID3 = 8'h0A;
  localparam logic [7:0] IDX_REV = 8'h0B;
  localparam logic [7:0] IDX_CSR = 8'h0C;
  localparam logic [7:0] IDX_NMR = 8'h0D;
  localparam logic [7:0] IDX_MDM = 8'h0E;
  localparam logic [7:0] IDX_RFC = 8'h0F;
  localparam logic [7:0] IDX_GDS = 8'h10;
  localparam logic [7:0] IDX_DMS = 8'h11;
  localparam logic [7:0] IDX_PID = 8'h12;
  localparam logic [7:0] IDX_CKA = 8'h13;

  // flow-character set lives above the indexed set in the same storage
  localparam logic [1:0] FLOW_SLOT_TOP = 2'h3;

  // writable bit masks
  localparam logic [7:0] MASK_FULL  = 8'hFF;
  localparam logic [7:0] MASK_LEVEL = 8'h7F;
  localparam logic [7:0] MASK_TCR   = 8'h0F;
  localparam logic [7:0] MASK_NMR   = 8'h3F;
  localparam logic [7:0] MASK_MDM   = 8'h0F;
  localparam logic [7:0] MASK_DMS   = 8'hC0;
  localparam logic [7:0] MASK_CKA   = 8'h1F;
  localparam logic [7:0] MASK_NONE  = 8'h00;
  localparam logic [1:0] ASR_WR_BITS = 2'h0;

  // reset values
  localparam logic [7:0] RST_CPR  = 8'h20;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [MEM_DEPTH*DATA_W-1:0] MEM_RESET_IMAGE =
    (MEM_DEPTH*DATA_W)'(RST_CPR) << (IDX_CPR * DATA_W);
  localparam logic [MEM_DEPTH-1:0] MEM_KEEP_MASK =
    (MEM_DEPTH'(1) << IDX_CKS) | (MEM_DEPTH'(1) << IDX_CKA);

  // where a read answer comes from
  typedef enum logic [1:0] {SRC_STD, SRC_MEM, SRC_HELD} icr_src_e;

  // control fields handed to the channel datapath
  typedef struct packed {
    logic [7:0] additional_control;
    logic [7:0] clock_prescaler;
    logic [7:0] sampling_clock_count;
    logic [7:0] clock_source_select;
    logic [7:0] ttl;
    logic [7:0] rtl;
    logic [7:0] flow_low_threshold;
    logic [7:0] flow_high_threshold;
    logic [7:0] nine_bit_mode_control;
    logic [7:0] modem_wakeup_mask;
    logic [1:0] dms_force;
    logic [7:0] clock_alteration;
    logic [7:0] efr;
    logic [7:0] xon1;
    logic [7:0] xon2;
    logic [7:0] xoff1;
    logic [7:0] xoff2;
  } icr_ctrl_s;

  // writable mask of an indexed offset; zero means read-only or unmapped
  function automatic logic [7:0] idx_wmask(input logic [7:0] idx);
    if (idx == IDX_ACR || idx == IDX_CPR || idx == IDX_CKS) return MASK_FULL;
    else if (idx == IDX_TCR) return MASK_TCR;
    else if (idx >= IDX_TTL && idx <= IDX_FCH) return MASK_LEVEL;
    else if (idx == IDX_NMR) return MASK_NMR;
    else if (idx == IDX_MDM) return MASK_MDM;
    else if (idx == IDX_DMS) return MASK_DMS;
    else if (idx == IDX_CKA) return MASK_CKA;
    else return MASK_NONE;
  endfunction

  // host addresses that map the flow-character set under the flow key
  function automatic logic is_flow_addr(input logic [2:0] a);
    return (a == ADDR_FLOW0) || (a >= ADDR_TFL);
  endfunction

endpackage

// [rtl/icr_regmem.sv]
// small register memory with reset image, selective soft clear and registered read
`timescale 1ns/100ps
module icr_regmem #(
  parameter int                         WIDTH      = 8,
  parameter int                         DEPTH      = 32,
  parameter int                         AW         = 5,
  parameter logic [DEPTH*WIDTH-1:0]     RESET_IMAGE = '0,
  parameter logic [DEPTH-1:0]           KEEP_MASK  = '0
) (
  // clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  // write side
  input  wire logic                     wr_en_in,
  input  wire logic [AW-1:0]            wr_addr_in,
  input  wire logic [WIDTH-1:0]         wr_data_in,
  input  wire logic                     clr_in,
  // read side
  input  wire logic [AW-1:0]            rd_addr_in,
  output logic      [WIDTH-1:0]         rd_data_out,
  output logic      [DEPTH*WIDTH-1:0]   dump_out
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  // storage: soft clear restores the image except for kept entries
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= RESET_IMAGE[i*WIDTH +: WIDTH];
      end
    end else if (clr_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!KEEP_MASK[i]) begin
          mem_reg[i] <= RESET_IMAGE[i*WIDTH +: WIDTH];
        end
      end
    end else if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  // read data always leaves through a register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem_reg[rd_addr_in];
    end
  end

  // flat view of every entry for the control outputs
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      dump_out[i*WIDTH +: WIDTH] = mem_reg[i];
    end
  end

endmodule // icr_regmem

// [sim/icr_indexed_ctrl_assertions.sv]
// concurrent checks on the ports of the indexed control register block
`timescale 1ns/100ps
module icr_indexed_ctrl_assertions
  import icr_pkg::*;
(
  // clock, reset, host port, standard file data and line format
  input wire logic       SYS_CLK_IN, RST_N_IN, CS_IN, RD_IN, WR_IN,
  input wire logic [2:0] ADDR_IN,
  input wire logic [7:0] DATA_IN, DATA_OUT, STD_WDATA_OUT, STD_RDATA_IN, LINE_FORMAT_OUT,
  // design outputs
  input wire logic       DATA_OE_OUT, STD_RD_OUT, STD_WR_OUT, CHAN_RESET_OUT,
  input wire logic [1:0] ASR_CTRL_OUT,
  input wire icr_pkg::icr_ctrl_s CFG_OUT
);
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  // decoded host requests; write wins over read
  logic rd_take;
  logic wr_take;
  assign rd_take = CS_IN && RD_IN && !WR_IN;
  assign wr_take = CS_IN && WR_IN;

  chk_read_answer: assert property (rd_take |-> ##2 DATA_OE_OUT)
    else $error("read answer missing");
  chk_answer_cause: assert property (DATA_OE_OUT |-> $past(rd_take, 2))
    else $error("answer without read");
  chk_std_write: assert property (wr_take && ADDR_IN == 3'h0 |=>
    STD_WR_OUT && STD_WDATA_OUT == $past(DATA_IN)) else $error("standard write lost");
  chk_std_read_data: assert property (STD_RD_OUT |=>
    DATA_OE_OUT && DATA_OUT == $past(STD_RDATA_IN)) else $error("standard read data wrong");
  chk_reset_cause: assert property (CHAN_RESET_OUT |->
    $past(wr_take && ADDR_IN == ADDR_WIN && DATA_IN == CSR_RESET_KEY))
    else $error("soft reset without key write");
  chk_reset_keeps_clock: assert property (CHAN_RESET_OUT |=> CFG_OUT.clock_prescaler == RST_CPR &&
    CFG_OUT.flow_low_threshold == 8'h00 && $stable(CFG_OUT.clock_source_select) && $stable(CFG_OUT.clock_alteration))
    else $error("soft reset result wrong");
  chk_level_bit_seven: assert property (!CFG_OUT.flow_low_threshold[7] && !CFG_OUT.flow_high_threshold[7] &&
    !CFG_OUT.ttl[7] && !CFG_OUT.rtl[7]) else $error("level bit 7 set");
  chk_line_format: assert property (wr_take && ADDR_IN == ADDR_LCR |->
    ##2 LINE_FORMAT_OUT == $past(DATA_IN, 2)) else $error("line format not taken");
  chk_asr_write_only: assert property ($changed(ASR_CTRL_OUT) |-> $past(wr_take, 2))
    else $error("status bits moved without write");

  // main scenarios reached
  cover property (CHAN_RESET_OUT);
  cover property (STD_RD_OUT ##1 DATA_OE_OUT);
  cover property (STD_WR_OUT);
endmodule // icr_indexed_ctrl_assertions

bind icr_indexed_ctrl icr_indexed_ctrl_assertions chk_u (.SYS_CLK_IN(SYS_CLK_IN),
  .RST_N_IN(RST_N_IN), .CS_IN(CS_IN), .RD_IN(RD_IN), .WR_IN(WR_IN), .ADDR_IN(ADDR_IN),
  .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .STD_WDATA_OUT(STD_WDATA_OUT),
  .STD_RDATA_IN(STD_RDATA_IN), .LINE_FORMAT_OUT(LINE_FORMAT_OUT), .DATA_OE_OUT(DATA_OE_OUT),
  .STD_RD_OUT(STD_RD_OUT), .STD_WR_OUT(STD_WR_OUT), .CHAN_RESET_OUT(CHAN_RESET_OUT),
  .ASR_CTRL_OUT(ASR_CTRL_OUT), .CFG_OUT(CFG_OUT));

// [sim/icr_indexed_ctrl_test.sv]
// self-checking bench for the indexed control register block
`timescale 1ns/100ps
module icr_indexed_ctrl_test;
  import icr_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cs = 1'b0, ren = 1'b0, wen = 1'b0;
  logic good = 1'b0, txr = 1'b0, rxr = 1'b0, oe, srd, swr, crst;
  logic [2:0] adr = 3'h0, sad;
  logic [7:0] din = 8'h00, dout, swd, srdat, lf;
  logic [7:0] sts = 8'hA4, receive_level = 8'h21, transmit_level = 8'h12, fcr = 8'h3C;
  logic [1:0] additional_status;
  icr_ctrl_s cfg;
  int n_errors = 0, total_checks = 0;
  always #10 clk = ~clk;

  icr_indexed_ctrl #(.ID1_VALUE(8'hA5)) dut_u (.SYS_CLK_IN(clk), .RST_N_IN(rst_n),
    .CS_IN(cs), .RD_IN(ren), .WR_IN(wen), .ADDR_IN(adr), .DATA_IN(din), .DATA_OUT(dout),
    .DATA_OE_OUT(oe), .STD_RD_OUT(srd), .STD_WR_OUT(swr), .STD_ADDR_OUT(sad),
    .STD_WDATA_OUT(swd), .STD_RDATA_IN(srdat), .ASR_STATUS_IN(sts), .RFL_IN(receive_level),
    .TFL_IN(transmit_level), .FCR_READBACK_IN(fcr), .GOOD_DATA_IN(good), .TXRDY_STAT_IN(txr),
    .RXRDY_STAT_IN(rxr), .CFG_OUT(cfg), .LINE_FORMAT_OUT(lf), .ASR_CTRL_OUT(additional_status),
    .CHAN_RESET_OUT(crst));
  icr_std_file_model std_u (.clk_in(clk), .rd_in(srd), .wr_in(swr), .addr_in(sad),
    .wdata_in(swd), .rdata_out(srdat));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // each access waits an edge first, so no signal is driven twice in one step
  task automatic put(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk); #1 cs = 1'b1; wen = 1'b1; adr = a; din = d;
    @(posedge clk); #1 cs = 1'b0; wen = 1'b0;
  endtask
  task automatic get(input logic [2:0] a, input logic [7:0] exp);
    int i;
    @(posedge clk); #1 cs = 1'b1; ren = 1'b1; adr = a;
    @(posedge clk); #1 cs = 1'b0; ren = 1'b0;
    for (i = 0; i < 4 && oe !== 1'b1; i++) @(posedge clk) #1;
    if (oe !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: no read answer", $time);
      give_verdict;
    end
    chk(dout, exp);
  endtask
  // select the index first, then move data through the window
  task automatic wput(input logic [7:0] i, input logic [7:0] d);
    put(ADDR_SPR, i);
    put(ADDR_WIN, d);
  endtask
  task automatic wget(input logic [7:0] i, input logic [7:0] exp);
    put(ADDR_SPR, i);
    get(ADDR_WIN, exp);
  endtask

  // only listed offsets, with the stored bits each one keeps
  logic [7:0] ix [10] = '{IDX_CPR, IDX_TCR, IDX_CKS, IDX_TTL, IDX_FCL, IDX_FCH,
                          IDX_NMR, IDX_MDM, IDX_DMS, IDX_CKA};
  logic [7:0] mk [10] = '{MASK_FULL, MASK_TCR, MASK_FULL, MASK_LEVEL, MASK_LEVEL,
                          MASK_LEVEL, MASK_NMR, MASK_MDM, MASK_DMS, MASK_CKA};

  initial begin
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk); #1 chk(cfg.clock_prescaler, RST_CPR);
    chk(lf, 8'h00);
    wput(IDX_ACR, 8'h40);
    wget(IDX_CPR, RST_CPR);
    wget(IDX_RTL, 8'h00);
    for (int k = 0; k < 10; k++) begin
      wput(ix[k], 8'hFF);
      wget(ix[k], mk[k]);
    end
    rxr = 1'b1;
    wget(IDX_DMS, 8'hC1);
    txr = 1'b1;
    wget(IDX_DMS, 8'hC3);
    wput(IDX_ID1, 8'hFF);
    wget(IDX_ID1, 8'hA5);
    good = 1'b1;
    wput(IDX_GDS, 8'hFE);
    wget(IDX_GDS, 8'h01);
    wget(IDX_RFC, fcr);
    wput(IDX_CSR, 8'h01);
    chk({7'h00, crst}, 8'h00);
    chk(cfg.clock_prescaler, 8'hFF);
    wput(IDX_ACR, 8'h00);
    get(ADDR_WIN, 8'h95);
    put(ADDR_SHARED1, 8'h5A);
    get(ADDR_SHARED1, 8'h5A);
    wput(IDX_ACR, 8'h80);
    get(ADDR_LCR, receive_level);
    get(ADDR_TFL, transmit_level);
    put(ADDR_SHARED1, 8'hFF);
    get(ADDR_SHARED1, {sts[7:2], 2'h3});
    chk({6'h00, additional_status}, 8'h03);
    get(ADDR_WIN, 8'h00);
    put(ADDR_TFL, 8'h77);
    put(ADDR_LCR, 8'h80);
    put(ADDR_SHARED1, 8'h33);
    get(ADDR_SHARED1, 8'h33);
    put(3'h0, 8'h6B);
    get(3'h0, 8'h6B);
    put(ADDR_LCR, 8'h03);
    wput(IDX_ACR, 8'h00);
    get(ADDR_TFL, 8'h77);
    // flow key: the index and window addresses reach the flow characters instead
    put(ADDR_LCR, LCR_FLOW_KEY);
    put(ADDR_SPR, 8'h44);
    put(ADDR_WIN, 8'h55);
    put(ADDR_LCR, 8'h03);
    @(posedge clk); #1 chk(cfg.xoff2, 8'h44);
    chk(cfg.xon2, 8'h55);
    chk(cfg.additional_control, 8'h00);
    get(ADDR_SPR, IDX_ACR);
    wput(IDX_CSR, CSR_RESET_KEY);
    chk({7'h00, crst}, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk(cfg.clock_prescaler, RST_CPR);
    chk(cfg.clock_source_select, 8'hFF);
    chk(cfg.clock_alteration, 8'h1F);
    chk(cfg.flow_low_threshold, 8'h00);
    chk(lf, 8'h00);
    give_verdict;
  end
  // hang guard: a run that stalls counts as a mismatch
  initial begin
    #(3000 * 20);
    n_errors++;
    give_verdict;
  end
endmodule // icr_indexed_ctrl_test

// [sim/icr_std_file_model.sv]
// behavioural standard register file of the channel
`timescale 1ns/100ps
module icr_std_file_model (
  // strobes from the block
  input  wire logic       clk_in,
  input  wire logic       rd_in,
  input  wire logic       wr_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wdata_in,
  // read data back
  output logic      [7:0] rdata_out
);
  logic [7:0] mem_reg [8];
  logic [7:0] last_reg;
  // distinct start values so a wrong address shows up
  initial begin
    for (int i = 0; i < 8; i++) mem_reg[i] = 8'h90 + 8'(i);
    last_reg = 8'h00;
  end
  always @(posedge clk_in) begin
    if (wr_in) mem_reg[addr_in] <= wdata_in;
    if (rd_in) last_reg <= mem_reg[addr_in];
  end
  // outside a read the bus shows the inverse of the last value, never a stale copy
  assign rdata_out = rd_in ? mem_reg[addr_in] : ~last_reg;
endmodule // icr_std_file_model
